// [test/bst_tap_monitor.sv]
`timescale 1ns/1ps
module bst_tap_monitor #(
    parameter int NUM_IOB = bst_pkg::DEF_IOBS
) (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic TCK_I,
    input wire logic TDO_O,
    input wire logic TDO_OE_O,
    input wire logic SCAN_OPTION_I,
    input wire logic GLOBAL_OUTPUT_FLOAT_I,
    input wire logic [NUM_IOB-1:0] CORE_OUT_I,
    input wire logic [NUM_IOB-1:0] CORE_OE_I,
    input wire logic [NUM_IOB-1:0] PAD_O,
    input wire logic [NUM_IOB-1:0] PAD_OE_O,
    input wire bst_pkg::bst_user_t USER_O,
    input wire logic CFG_STROBE_O,
    input wire logic READBACK_STROBE_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    a_oe_needs_option: assert property (TDO_OE_O |-> $past(SCAN_OPTION_I))
        else $error("tdo enabled without scan option");
    a_float_pads: assert property (
        $past(!SCAN_OPTION_I && GLOBAL_OUTPUT_FLOAT_I) |-> PAD_OE_O == '0)
        else $error("pads driven while floated");
    a_pad_follow: assert property (
        $past(!SCAN_OPTION_I && !GLOBAL_OUTPUT_FLOAT_I && !SYS_RST_I)
        |-> PAD_O == $past(CORE_OUT_I) && PAD_OE_O == $past(CORE_OE_I))
        else $error("pads not following core logic");
    a_tdo_on_fall: assert property ($changed(TDO_O) && !$past(SYS_RST_I)
        |-> !$past(TCK_I, 2))
        else $error("tdo changed away from a test clock fall");
    a_sel_excl: assert property (!(USER_O.sel1 && USER_O.sel2))
        else $error("both user selects active");
    a_user_states: assert property ($onehot0({USER_O.reset, USER_O.update,
        USER_O.shift, USER_O.capture}))
        else $error("user state decodes overlap");
    a_update_holds: assert property ($rose(USER_O.update) |-> USER_O.update [*8])
        else $error("update decode shorter than a test clock phase");
    a_strobe_excl: assert property (!(CFG_STROBE_O && READBACK_STROBE_O))
        else $error("config and readback strobes together");
    a_cfg_pulse: assert property (CFG_STROBE_O |=> !CFG_STROBE_O [*8])
        else $error("config strobe not a single pulse");
    a_rb_pulse: assert property (READBACK_STROBE_O |=> !READBACK_STROBE_O [*8])
        else $error("readback strobe not a single pulse");
    c_user1: cover property (USER_O.sel1);
    c_cfg: cover property (CFG_STROBE_O);
    c_drive: cover property (&PAD_OE_O);
    c_tdo: cover property (TDO_OE_O);
endmodule
bind bst_tap bst_tap_monitor #(.NUM_IOB(NUM_IOB)) u_mon (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .TCK_I(TCK_I), .TDO_O(TDO_O), .TDO_OE_O(TDO_OE_O), .SCAN_OPTION_I(SCAN_OPTION_I),
    .GLOBAL_OUTPUT_FLOAT_I(GLOBAL_OUTPUT_FLOAT_I), .CORE_OUT_I(CORE_OUT_I),
    .CORE_OE_I(CORE_OE_I), .PAD_O(PAD_O), .PAD_OE_O(PAD_OE_O), .USER_O(USER_O),
    .CFG_STROBE_O(CFG_STROBE_O), .READBACK_STROBE_O(READBACK_STROBE_O));

// [test/bst_tester.sv]
`timescale 1ns/1ps
module bst_tester (
    input wire logic clk,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one test clock of 125 ns; tck rests low between frames
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (13) @(negedge clk);
        tck = 1'b1;
        q = tdo;
        repeat (12) @(negedge clk);
        tck = 1'b0;
    endtask
    task automatic go(input logic [7:0] seq, input int n);
        logic q;
        for (int i = 0; i < n; i++) step(seq[i], ~tdi, q);
    endtask
    task automatic reset_tap();
        go(8'h1F, 6);
    endtask
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
        output logic [31:0] dout);
        logic q;
        dout = '0;
        go(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        go(8'h01, 2);
    endtask
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
    import bst_pkg::*;
    typedef struct {logic [2:0] code; logic [31:0] dout; logic [1:0] sel;} bst_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe, cstb, cfg_d;
    logic opt = 1'b1, done = 1'b0, indes = 1'b0, flt = 1'b1;
    logic [7:0] cout = '0, coe = '0, pad_i = '0, pad_o, pad_oe, core_in;
    bst_user_t usr;
    int n_errors = 0, cmp_count = 0, cyc = 0, nstb = 0, n_gated = 0;
    // released tdo reads inverted so a bit taken while undriven shows up
    wire tdo_pin = tdo_oe ? tdo : ~tdo;
    logic [31:0] q, d;
    bst_row_t rows [8] = '{'{IR_EXTEST, 32'h0100_0000, 2'h0}, '{IR_SAMPLE, 32'h0100_0000, 2'h0},
        '{IR_USER1, 32'hFFFF_FFFF, 2'h2}, '{IR_USER2, 32'h0, 2'h1},
        '{IR_READBACK, 32'hFFFF_FFFF, 2'h0}, '{IR_CONFIGURE, 32'h0, 2'h0},
        '{3'h6, 32'h2, 2'h0}, '{IR_BYPASS, 32'h2, 2'h0}};
    bst_tap #(.NUM_IOB(8)) dut (.CLK_I(clk), .SYS_RST_I(rst), .TCK_I(tck), .TMS_I(tms),
        .TDI_I(tdi), .TDO_O(tdo), .TDO_OE_O(tdo_oe), .SCAN_OPTION_I(opt), .CONFIG_DONE_I(done),
        .SCAN_IN_DESIGN_I(indes), .GLOBAL_OUTPUT_FLOAT_I(flt), .CORE_OUT_I(cout),
        .CORE_OE_I(coe), .CORE_IN_O(core_in), .PAD_I(pad_i), .PAD_O(pad_o), .PAD_OE_O(pad_oe),
        .USER_TDO1_I(1'b1), .USER_TDO2_I(1'b0), .USER_O(usr), .CFG_DOUT_I(1'b0),
        .READBACK_DATA_I(1'b1), .CFG_DATA_O(cfg_d), .CFG_STROBE_O(cstb), .READBACK_STROBE_O());
    bst_tester u_tst (.clk(clk), .tdo(tdo_pin), .tck(tck), .tms(tms), .tdi(tdi));
    initial forever #2.5 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cstb) nstb++;
        if (tdo_oe && done && !indes) n_gated++;
        if (cyc == 60000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (4) @(negedge clk);
        chk("oe_in_reset", 32'h0, {pad_oe, tdo_oe});
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("usr_reset", 32'h1, {31'h0, usr.reset});
        u_tst.reset_tap();
        u_tst.scan(1'b1, 32'h7, 3, q);
        chk("ir_capture", {29'h0, IR_CAPTURE}, q);
        foreach (rows[i]) begin
            u_tst.scan(1'b1, {29'h0, rows[i].code}, 3, q);
            u_tst.scan(1'b0, 32'h1, 32, q);
            chk("dr_out", rows[i].dout, q);
            chk("user_sel", {30'h0, rows[i].sel}, {30'h0, usr.sel1, usr.sel2});
        end
        u_tst.scan(1'b1, {29'h0, IR_CONFIGURE}, 3, q);
        nstb = 0;
        u_tst.scan(1'b0, 32'h0, 5, q);
        chk("cfg_strobes", 32'h5, 32'(nstb));
        pad_i = 8'hA5;
        cout = 8'h0F;
        coe = 8'hF0;
        u_tst.scan(1'b1, {29'h0, IR_SAMPLE}, 3, q);
        u_tst.scan(1'b0, 32'h0, 24, q);
        for (int g = 0; g < 8; g++) chk("cells", {coe[g], cout[g], pad_i[g]}, q[3*g+:3]);
        d = '0;
        for (int g = 0; g < 8; g++) d[3*g+:3] = {1'b1, g[0], 1'b0};
        u_tst.scan(1'b1, {29'h0, IR_EXTEST}, 3, q);
        u_tst.scan(1'b0, d, 24, q);
        chk("pad_oe", 32'hFF, {24'h0, pad_oe});
        chk("pad_o", 32'hAA, {24'h0, pad_o});
        done = 1'b1;
        u_tst.scan(1'b1, {29'h0, IR_USER1}, 3, q);
        chk("gated_sel", 32'h0, {31'h0, usr.sel1});
        chk("gated_oe", 32'h0, 32'(n_gated));
        indes = 1'b1;
        u_tst.scan(1'b1, {29'h0, IR_USER1}, 3, q);
        chk("enabled_sel", 32'h1, {31'h0, usr.sel1});
        u_tst.scan(1'b1, {29'h0, IR_CONFIGURE}, 3, q);
        nstb = 0;
        u_tst.scan(1'b0, 32'h0, 5, q);
        chk("cfg_after_done", 32'h0, 32'(nstb));
        opt = 1'b0;
        repeat (4) @(negedge clk);
        flt = 1'b0;
        cout = 8'h3C;
        repeat (4) @(negedge clk);
        chk("pad_follow", 32'h3C, {24'h0, pad_o});
        chk("oe_follow", 32'hF0, {24'h0, pad_oe});
        chk("core_in", 32'hA5, {24'h0, core_in});
        chk("cfg_data", {31'h0, tdi}, {31'h0, cfg_d});
        summarize();
    end
endmodule

// [verilog/bst_pkg.sv]
package bst_pkg;
    localparam int IR_W = 3;
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_SAMPLE = 3'h1;
    localparam logic [2:0] IR_USER1 = 3'h2;
    localparam logic [2:0] IR_USER2 = 3'h3;
    localparam logic [2:0] IR_READBACK = 3'h4;
    localparam logic [2:0] IR_CONFIGURE = 3'h5;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    localparam logic [2:0] IR_CAPTURE = 3'h1;
    localparam int CELLS_PER_IOB = 3;
    localparam int CELL_OE = 2;
    localparam int CELL_OUT = 1;
    localparam int CELL_IN = 0;
    localparam int DEF_IOBS = 8;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } bst_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bst_tap_in_t;

    typedef struct packed {
        logic reset;
        logic update;
        logic shift;
        logic capture;
        logic sel1;
        logic sel2;
    } bst_user_t;
endpackage

// [verilog/bst_tap.sv]
`timescale 1ns/1ps
// Operation
// - extest, sample/preload, bypass with needed registers
// - two user instructions accepted
// - scan option turns pins into test port
// - every io block scanned as bidirectional pin
// - no internal-test instruction supported
// - four wires, reset only via tms
// - sixteen-state controller, instruction and data registers
// - three boundary cells per io block
// - public always before config, after only if enabled
// - configure and read back through scan path
// - user reset, update, shift outputs decoded
// - extest capture samples all pins together
// - cell order output-enable, output, input
// - bypass is one flip-flop tdi to tdo
// - output float except enabled extest
module bst_tap #(
    parameter int NUM_IOB = bst_pkg::DEF_IOBS
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // test port pins
    input wire logic TCK_I,
    input wire logic TMS_I,
    input wire logic TDI_I,
    output logic TDO_O,
    output logic TDO_OE_O,
    // device status
    input wire logic SCAN_OPTION_I,
    input wire logic CONFIG_DONE_I,
    input wire logic SCAN_IN_DESIGN_I,
    input wire logic GLOBAL_OUTPUT_FLOAT_I,
    // io blocks: core side
    input wire logic [NUM_IOB-1:0] CORE_OUT_I,
    input wire logic [NUM_IOB-1:0] CORE_OE_I,
    output logic [NUM_IOB-1:0] CORE_IN_O,
    // io blocks: pad side
    input wire logic [NUM_IOB-1:0] PAD_I,
    output logic [NUM_IOB-1:0] PAD_O,
    output logic [NUM_IOB-1:0] PAD_OE_O,
    // user scan registers
    input wire logic USER_TDO1_I,
    input wire logic USER_TDO2_I,
    output bst_pkg::bst_user_t USER_O,
    // configuration path
    input wire logic CFG_DOUT_I,
    input wire logic READBACK_DATA_I,
    output logic CFG_DATA_O,
    output logic CFG_STROBE_O,
    output logic READBACK_STROBE_O
);
    import bst_pkg::*;

    localparam int BSR_W = NUM_IOB * CELLS_PER_IOB;

    if (NUM_IOB < 1) begin : g_bad_iobs
        $error("NUM_IOB must be at least one");
    end

    // two-stage synchronisers for tck, tms, tdi and the pads
    bst_tap_in_t sync1_ff, sync2_ff;
    logic tck_prev_ff;
    logic [NUM_IOB-1:0] pad_s1_ff, pad_s2_ff;

    always_ff @(posedge CLK_I) begin
        sync1_ff <= '{tck: TCK_I, tms: TMS_I, tdi: TDI_I};
        sync2_ff <= sync1_ff;
        pad_s1_ff <= PAD_I;
        pad_s2_ff <= pad_s1_ff;
        tck_prev_ff <= SYS_RST_I ? 1'b0 : sync2_ff.tck;
    end

    wire tck_rise = sync2_ff.tck & ~tck_prev_ff;
    wire tck_fall = ~sync2_ff.tck & tck_prev_ff;

    bst_state_t state;

    bst_tap_fsm u_fsm (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .step_i(tck_rise),
        .tms_i(sync2_ff.tms),
        .state_o(state)
    );

    // instruction, boundary, bypass and tdo output registers
    logic [IR_W-1:0] ir_sh_ff, ir_ff;
    logic [BSR_W-1:0] bsr_sh_ff, bsr_upd_ff;
    logic bypass_ff;
    logic tdo_ff, tdo_oe_ff;

    // gating: public always before config, after config only when enabled
    wire scan_on = SCAN_OPTION_I & (~CONFIG_DONE_I | SCAN_IN_DESIGN_I);
    wire is_ext = scan_on & (ir_ff == IR_EXTEST);
    wire is_samp = scan_on & (ir_ff == IR_SAMPLE);
    wire is_u1 = scan_on & (ir_ff == IR_USER1);
    wire is_u2 = scan_on & (ir_ff == IR_USER2);
    wire is_rb = scan_on & (ir_ff == IR_READBACK);
    wire is_cfg = scan_on & (ir_ff == IR_CONFIGURE) & ~CONFIG_DONE_I;
    // reserved, bypass, unknown codes (incl. internal test) select bypass
    wire is_byp = ~(is_ext | is_samp | is_u1 | is_u2 | is_rb | is_cfg);

    // capture vector: per io block oe, out, in (oe nearest tdi)
    logic [BSR_W-1:0] cap_vec;
    genvar g;
    generate
        for (g = 0; g < NUM_IOB; g++) begin : g_cell
            assign cap_vec[g*CELLS_PER_IOB + CELL_OE] = CORE_OE_I[g];
            assign cap_vec[g*CELLS_PER_IOB + CELL_OUT] = CORE_OUT_I[g];
            assign cap_vec[g*CELLS_PER_IOB + CELL_IN] = pad_s2_ff[g];
        end
    endgenerate

    wire bsr_sel = is_ext | is_samp;
    wire st_cap_dr = (state == CAP_DR);
    wire st_sh_dr = (state == SH_DR);
    wire st_upd_dr = (state == UPD_DR);

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            ir_sh_ff <= IR_BYPASS;
            ir_ff <= IR_BYPASS;
        end else if (tck_rise) begin
            case (state)
                TLR: ir_ff <= IR_BYPASS;
                CAP_IR: ir_sh_ff <= IR_CAPTURE;
                SH_IR: ir_sh_ff <= {sync2_ff.tdi, ir_sh_ff[IR_W-1:1]};
                UPD_IR: ir_ff <= ir_sh_ff;
                default: ir_sh_ff <= ir_sh_ff;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            bsr_sh_ff <= '0;
            bsr_upd_ff <= '0;
            bypass_ff <= 1'b0;
        end else if (tck_rise) begin
            if (bsr_sel && st_cap_dr) begin
                bsr_sh_ff <= cap_vec;
            end else if (bsr_sel && st_sh_dr) begin
                bsr_sh_ff <= {sync2_ff.tdi, bsr_sh_ff[BSR_W-1:1]};
            end
            if (bsr_sel && st_upd_dr) begin
                bsr_upd_ff <= bsr_sh_ff;
            end
            if (st_cap_dr) begin
                bypass_ff <= 1'b0;
            end else if (st_sh_dr) begin
                bypass_ff <= sync2_ff.tdi;
            end
        end
    end

    // serial output source selection
    wire cfg_src = is_cfg ? CFG_DOUT_I : READBACK_DATA_I;
    wire usr_src = is_u1 ? USER_TDO1_I : USER_TDO2_I;
    wire dr_src = bsr_sel ? bsr_sh_ff[0] :
                  (is_u1 | is_u2) ? usr_src :
                  is_byp ? bypass_ff : cfg_src;
    wire tdo_src = (state == SH_IR) ? ir_sh_ff[0] : dr_src;
    wire tdo_en = (state == SH_IR) | st_sh_dr;

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            tdo_ff <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else if (tck_fall) begin
            tdo_ff <= tdo_src;
            tdo_oe_ff <= tdo_en & scan_on;
        end
    end

    // pad drive: extest from cells, else core gated by output float
    logic [NUM_IOB-1:0] ext_out, ext_oe;
    generate
        for (g = 0; g < NUM_IOB; g++) begin : g_pad
            assign ext_out[g] = bsr_upd_ff[g*CELLS_PER_IOB + CELL_OUT];
            assign ext_oe[g] = bsr_upd_ff[g*CELLS_PER_IOB + CELL_OE];
        end
    endgenerate

    wire [NUM_IOB-1:0] nxt_pad_o = is_ext ? ext_out : CORE_OUT_I;
    wire [NUM_IOB-1:0] nxt_pad_oe = is_ext ? ext_oe :
        (GLOBAL_OUTPUT_FLOAT_I ? '0 : CORE_OE_I);

    logic [NUM_IOB-1:0] pad_o_ff, pad_oe_ff, core_in_ff;
    bst_user_t user_ff;
    logic cfg_data_ff, cfg_stb_ff, rb_stb_ff;

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            pad_o_ff <= '0;
            pad_oe_ff <= '0;
            core_in_ff <= '0;
            user_ff <= '0;
            cfg_data_ff <= 1'b0;
            cfg_stb_ff <= 1'b0;
            rb_stb_ff <= 1'b0;
        end else begin
            pad_o_ff <= nxt_pad_o;
            pad_oe_ff <= nxt_pad_oe;
            core_in_ff <= pad_s2_ff;
            user_ff.reset <= (state == TLR);
            user_ff.update <= st_upd_dr;
            user_ff.shift <= st_sh_dr;
            user_ff.capture <= st_cap_dr;
            user_ff.sel1 <= is_u1;
            user_ff.sel2 <= is_u2;
            cfg_data_ff <= sync2_ff.tdi;
            cfg_stb_ff <= tck_rise & st_sh_dr & is_cfg;
            rb_stb_ff <= tck_rise & st_sh_dr & is_rb;
        end
    end

    assign TDO_O = tdo_ff;
    assign TDO_OE_O = tdo_oe_ff;
    assign PAD_O = pad_o_ff;
    assign PAD_OE_O = pad_oe_ff;
    assign CORE_IN_O = core_in_ff;
    assign USER_O = user_ff;
    assign CFG_DATA_O = cfg_data_ff;
    assign CFG_STROBE_O = cfg_stb_ff;
    assign READBACK_STROBE_O = rb_stb_ff;
endmodule

// [verilog/bst_tap_fsm.sv]
`timescale 1ns/1ps
module bst_tap_fsm (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic step_i,
    input wire logic tms_i,
    output bst_pkg::bst_state_t state_o
);
    import bst_pkg::*;

    bst_state_t state_ff;
    bst_state_t nxt_state;

    always_comb begin
        case (state_ff)
            TLR: nxt_state = tms_i ? TLR : RTI;
            RTI: nxt_state = tms_i ? SEL_DR : RTI;
            SEL_DR: nxt_state = tms_i ? SEL_IR : CAP_DR;
            CAP_DR: nxt_state = tms_i ? EX1_DR : SH_DR;
            SH_DR: nxt_state = tms_i ? EX1_DR : SH_DR;
            EX1_DR: nxt_state = tms_i ? UPD_DR : PA_DR;
            PA_DR: nxt_state = tms_i ? EX2_DR : PA_DR;
            EX2_DR: nxt_state = tms_i ? UPD_DR : SH_DR;
            UPD_DR: nxt_state = tms_i ? SEL_DR : RTI;
            SEL_IR: nxt_state = tms_i ? TLR : CAP_IR;
            CAP_IR: nxt_state = tms_i ? EX1_IR : SH_IR;
            SH_IR: nxt_state = tms_i ? EX1_IR : SH_IR;
            EX1_IR: nxt_state = tms_i ? UPD_IR : PA_IR;
            PA_IR: nxt_state = tms_i ? EX2_IR : PA_IR;
            EX2_IR: nxt_state = tms_i ? UPD_IR : SH_IR;
            UPD_IR: nxt_state = tms_i ? SEL_DR : RTI;
            default: nxt_state = TLR;
        endcase
    end

    // no test reset pin: five tck with tms high reach TLR
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= TLR;
        end else if (step_i) begin
            state_ff <= nxt_state;
        end
    end

    assign state_o = state_ff;
endmodule
